// File: hdl/dcc_channel.sv
`timescale 1ns/1ps

// one comparator: synchroniser, edge flags and control bits
module dcc_channel
(
  input  wire logic                 core_clk_i,   // system clock
  input  wire logic                 rst_n_i,      // async reset, active low
  input  wire logic                 cmp_raw_i,    // analog comparator output
  input  wire logic                 wr_i,         // write strobe for this register
  input  wire logic [7:0]           wdata_i,      // write data
  output logic      [7:0]           rdata_o,      // register read value
  output dcc_pkg::dcc_trim_type     trim_o,       // analog trim settings
  output logic                      pin_out_o     // output toward port pin
);

  logic       sync1;
  logic       sync2;
  logic       sync3;
  logic       on;
  logic       rise_flag;
  logic       fall_flag;
  logic [1:0] pos_hyst_sel;
  logic [1:0] neg_hyst_sel;
  logic       rise_evt;
  logic       fall_evt;

  // ****************************************
  // synchroniser
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end
    else
    begin
      sync1 <= cmp_raw_i;  // R12
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // edges count only while enabled
  assign rise_evt = on && sync2 && !sync3;  // R10 R11
  assign fall_evt = on && !sync2 && sync3;  // R10 R11

  // ****************************************
  // control fields
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      on           <= 1'b0;
      pos_hyst_sel <= dcc_pkg::HYST_OFF;
      neg_hyst_sel <= dcc_pkg::HYST_OFF;
    end
    else if (wr_i)
    begin
      on           <= wdata_i[dcc_pkg::ON_BIT];                          // R1
      pos_hyst_sel <= wdata_i[dcc_pkg::POS_HYST_LSB +: 2];               // R5
      neg_hyst_sel <= wdata_i[dcc_pkg::NEG_HYST_LSB +: 2];               // R6
    end
  end

  // ****************************************
  // sticky edge flags, set wins over clear
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rise_flag <= 1'b0;
      fall_flag <= 1'b0;
    end
    else
    begin
      if (rise_evt)
        rise_flag <= 1'b1;  // R3 R9
      else if (wr_i)
        rise_flag <= wdata_i[dcc_pkg::RISE_BIT];
      if (fall_evt)
        fall_flag <= 1'b1;  // R4 R9
      else if (wr_i)
        fall_flag <= wdata_i[dcc_pkg::FALL_BIT];
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb
  begin
    rdata_o                             = dcc_pkg::CONTROL_RESET;
    rdata_o[dcc_pkg::ON_BIT]            = on;
    rdata_o[dcc_pkg::RESULT_BIT]        = sync2;  // R2
    rdata_o[dcc_pkg::RISE_BIT]          = rise_flag;
    rdata_o[dcc_pkg::FALL_BIT]          = fall_flag;
    rdata_o[dcc_pkg::POS_HYST_LSB +: 2] = pos_hyst_sel;
    rdata_o[dcc_pkg::NEG_HYST_LSB +: 2] = neg_hyst_sel;
  end

  assign trim_o.on           = on;
  assign trim_o.pos_hyst_sel = pos_hyst_sel;
  assign trim_o.neg_hyst_sel = neg_hyst_sel;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pin_out_o <= 1'b0;
    else
      pin_out_o <= on && sync2;  // R11
  end

endmodule : dcc_channel

// File: hdl/dcc_pkg.sv
package dcc_pkg;

  // ****************************************
  // register map and field layout
  // ****************************************
  localparam logic [7:0] CMP0_CONTROL_ADDR = 8'h9E;
  localparam logic [7:0] CMP1_CONTROL_ADDR = 8'h9F;
  localparam logic [7:0] CONTROL_RESET     = 8'h00;
  localparam int unsigned ON_BIT           = 7;
  localparam int unsigned RESULT_BIT       = 6;
  localparam int unsigned RISE_BIT         = 5;
  localparam int unsigned FALL_BIT         = 4;
  localparam int unsigned POS_HYST_LSB     = 2;
  localparam int unsigned NEG_HYST_LSB     = 0;
  localparam int unsigned NUM_CMP          = 2;

  // ****************************************
  // hysteresis selections
  // ****************************************
  localparam logic [1:0] HYST_OFF  = 2'h0;
  localparam logic [1:0] HYST_2MV  = 2'h1;
  localparam logic [1:0] HYST_4MV  = 2'h2;
  localparam logic [1:0] HYST_10MV = 2'h3;

  // settings to the analog trim of one comparator
  typedef struct packed {
    logic       on;
    logic [1:0] pos_hyst_sel;
    logic [1:0] neg_hyst_sel;
  } dcc_trim_type;

endpackage : dcc_pkg

// File: hdl/dcc_top.sv
`timescale 1ns/1ps

// Notes on behaviour
// [R1] bit 7 enables comparator, read/write
// [R2] bit 6 reads live comparator result
// [R3] bit 5 sticky rising-edge flag
// [R4] bit 4 sticky falling-edge flag
// [R5] bits 3-2 select positive hysteresis
// [R6] bits 1-0 select negative hysteresis
// [R7] comparator 0 register at 0x9E
// [R8] comparator 1 register at 0x9F, resets zero
// [R9] edge flags cleared only by software
// [R10] both edges raise events and flags
// [R11] disabled: pin output low, events suspended
// [R12] two-stage synchroniser before edge detection
module dcc_top
(
  input  wire logic                 core_clk_i,     // system clock, 100 MHz
  input  wire logic                 rst_n_i,        // async reset, active low
  input  wire logic [7:0]           sfr_addr_i,     // special-function register address
  input  wire logic                 sfr_wr_i,       // write strobe, one cycle
  input  wire logic [7:0]           sfr_wdata_i,    // write data
  output logic      [7:0]           sfr_rdata_o,    // read data, combinational
  output logic                      sfr_hit_o,      // address belongs to this block
  input  wire logic [1:0]           cmp_raw_i,      // comparator outputs, asynchronous
  output dcc_pkg::dcc_trim_type     cmp0_trim_o,    // comparator 0 trim
  output dcc_pkg::dcc_trim_type     cmp1_trim_o,    // comparator 1 trim
  output logic [1:0]                cmp_pin_out_o   // outputs toward port pins
);

  logic [1:0] wr_sel;
  logic [7:0] rdata [2];
  dcc_pkg::dcc_trim_type trim [2];

  // ****************************************
  // address decode
  // ****************************************
  assign wr_sel[0] = sfr_wr_i && (sfr_addr_i == dcc_pkg::CMP0_CONTROL_ADDR);  // R7
  assign wr_sel[1] = sfr_wr_i && (sfr_addr_i == dcc_pkg::CMP1_CONTROL_ADDR);  // R8

  always_comb
  begin
    sfr_hit_o   = 1'b1;
    sfr_rdata_o = 8'h00;
    case (sfr_addr_i)
      dcc_pkg::CMP0_CONTROL_ADDR: sfr_rdata_o = rdata[0];  // R7
      dcc_pkg::CMP1_CONTROL_ADDR: sfr_rdata_o = rdata[1];  // R8
      default:                    sfr_hit_o   = 1'b0;
    endcase
  end

  // ****************************************
  // comparator channels
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cmp
      dcc_channel u_channel
      (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .cmp_raw_i  (cmp_raw_i[gi]),
        .wr_i       (wr_sel[gi]),
        .wdata_i    (sfr_wdata_i),
        .rdata_o    (rdata[gi]),
        .trim_o     (trim[gi]),
        .pin_out_o  (cmp_pin_out_o[gi])
      );
    end
  endgenerate

  assign cmp0_trim_o = trim[0];
  assign cmp1_trim_o = trim[1];

endmodule : dcc_top

// File: verification/dcc_sva.sv
`timescale 1ns/1ps
// ****
// register and edge flag checks
// ****
module dcc_sva
(
  input wire logic                  core_clk_i, rst_n_i, sfr_wr_i, sfr_hit_o,
  input wire logic [7:0]            sfr_addr_i, sfr_wdata_i, sfr_rdata_o,
  input wire logic [1:0]            cmp_raw_i, cmp_pin_out_o,
  input wire dcc_pkg::dcc_trim_type cmp0_trim_o, cmp1_trim_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire a0 = sfr_addr_i == 8'h9E;
  sequence s_rise; !cmp_raw_i[0] ##1 cmp_raw_i[0] [*2]; endsequence
  a_hit_decode: assert property (sfr_hit_o == (a0 || sfr_addr_i == 8'h9F)) else $error("hit decode");
  a_miss_zero: assert property (!sfr_hit_o |-> sfr_rdata_o == 8'h00) else $error("off map read");
  a_trim0_write: assert property (sfr_wr_i && a0 |=>
    cmp0_trim_o == {$past(sfr_wdata_i[7]), $past(sfr_wdata_i[3:0])}) else $error("trim 0");
  a_trim1_write: assert property (sfr_wr_i && sfr_addr_i == 8'h9F |=>
    cmp1_trim_o == {$past(sfr_wdata_i[7]), $past(sfr_wdata_i[3:0])}) else $error("trim 1");
  a_off_pin_low: assert property (!cmp0_trim_o.on |=> !cmp_pin_out_o[0]) else $error("pin on");
  a_sync_result: assert property (s_rise |=> !a0 || sfr_rdata_o[6]) else $error("result");
  a_rise_flag: assert property (a0 && $past(a0) && $rose(sfr_rdata_o[6]) && cmp0_trim_o.on && !sfr_wr_i
    |=> !a0 || sfr_rdata_o[5]) else $error("rise flag");
  a_fall_flag: assert property (a0 && $past(a0) && $fell(sfr_rdata_o[6]) && cmp0_trim_o.on && !sfr_wr_i
    |=> !a0 || sfr_rdata_o[4]) else $error("fall flag");
  a_flag_hold: assert property (a0 && sfr_rdata_o[5] && !sfr_wr_i |=> !a0 || sfr_rdata_o[5]) else $error("held");
  a_off_no_flag: assert property (a0 && !sfr_rdata_o[4] && !cmp0_trim_o.on && !sfr_wr_i
    |=> !a0 || !sfr_rdata_o[4]) else $error("flag while off");
endmodule : dcc_sva

bind dcc_top dcc_sva chk (.*);

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic                  core_clk_i = 0, rst_n_i = 0, sfr_wr_i = 0, sfr_hit_o;
  logic [7:0]            sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
  logic [1:0]            cmp_raw_i = 2'h0, cmp_pin_out_o;
  dcc_pkg::dcc_trim_type cmp0_trim_o, cmp1_trim_o;
  int                    num_errors = 0, samples_checked = 0;
  always #5 core_clk_i = ~core_clk_i;
  dcc_top uut (.*);
  // ****
  // shared tasks
  // ****
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task put(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b0;
    #1;
  endtask : put
  task raw(input int n, input logic v);
    @(posedge core_clk_i);
    cmp_raw_i[n] <= v;
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask : raw
  task close_out;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task t_reset;
    @(posedge core_clk_i);
    sfr_addr_i <= 8'h9E;
    #1;
    chk(sfr_rdata_o, 8'h00);
    chk({3'h0, cmp1_trim_o}, 8'h00);
    chk({6'h0, cmp_pin_out_o}, 8'h00);
  endtask : t_reset
  task t_regs;
    logic [7:0] v;
    for (int k = 0; k < 4; k++)
    begin
      v = {4'h8, k[1:0], ~k[1:0]};
      put(8'h9E, v);
      chk(sfr_rdata_o, v);
      chk({3'h0, cmp0_trim_o}, {3'h0, v[7], v[3:0]});
    end
    put(8'h9F, 8'hFF);
    chk(sfr_rdata_o, 8'hBF);
    put(8'hA0, 8'h55);
    chk({sfr_rdata_o[6:0], sfr_hit_o}, 8'h00);
    put(8'h9F, 8'h00);
    chk(sfr_rdata_o, 8'h00);
  endtask : t_regs
  task t_edges;
    put(8'h9E, 8'h80);
    raw(0, 1'b1);
    chk(sfr_rdata_o, 8'hE0);
    chk({6'h0, cmp_pin_out_o}, 8'h01);
    raw(0, 1'b0);
    chk(sfr_rdata_o, 8'hB0);
    repeat (8) @(posedge core_clk_i);
    chk(sfr_rdata_o, 8'hB0);
    put(8'h9E, 8'h80);
    chk(sfr_rdata_o, 8'h80);
  endtask : t_edges
  task t_off;
    put(8'h9F, 8'h00);
    raw(1, 1'b1);
    chk(sfr_rdata_o, 8'h40);
    chk({6'h0, cmp_pin_out_o}, 8'h00);
    raw(1, 1'b0);
    chk(sfr_rdata_o, 8'h00);
  endtask : t_off
  initial
  begin
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_regs;
    t_edges;
    t_off;
    close_out;
  end
  initial
  begin
    #20000;
    num_errors++;
    close_out;
  end
endmodule : tb
